// ==== hdl/display_timing_pkg.sv ====
// constants, register map and carrier types of the display clock and sync block
package display_timing_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] SYS_CONFIG_TWO_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PIXEL_FREQ_FACTOR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SYNC_CONTROL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] LINES_PER_FIELD_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] HORIZONTAL_PERIOD_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] VERTICAL_SYNC_DELAY_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] HORIZONTAL_SYNC_DELAY_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] VERTICAL_CLAMP_BEGIN_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] VERTICAL_CLAMP_END_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] HORIZONTAL_CLAMP_BEGIN_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] HORIZONTAL_CLAMP_END_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] BACKGROUND_COLOUR_OFS = 8'h2C;
  localparam logic [ADDR_W-1:0] LAYER_SIZE_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] TIMING_STATUS_OFS = 8'h34;
  localparam int BUS_SEL_BIT = 8;
  localparam int MASTER_SLAVE_SELECT_BIT = 0;
  localparam int VP_BIT = 3;
  localparam int HP_BIT = 4;
  localparam int CORP_BIT = 5;
  localparam int BLANKP_BIT = 6;
  localparam int LAYER_H_LSB = 16;
  localparam logic [15:0] SYS_CONFIG_TWO_RST = 16'h0000;
  localparam logic [10:0] PIXEL_FACTOR_RST = 11'h148;
  localparam logic [15:0] SYNC_CONTROL_RST = 16'h0000;
  localparam logic [9:0] LINES_PER_FIELD_RST = 10'h271;
  localparam logic [11:0] HORIZONTAL_PERIOD_RST = 12'h855;
  localparam logic [9:0] VERTICAL_SYNC_DELAY_RST = 10'h020;
  localparam logic [10:0] HORIZONTAL_SYNC_DELAY_RST = 11'h048;
  localparam logic [9:0] VERTICAL_CLAMP_BEGIN_RST = 10'h001;
  localparam logic [9:0] VERTICAL_CLAMP_END_RST = 10'h005;
  localparam logic [8:0] HORIZONTAL_CLAMP_BEGIN_RST = 9'h000;
  localparam logic [8:0] HORIZONTAL_CLAMP_END_RST = 9'h009;
  localparam logic [15:0] BACKGROUND_COLOUR_RST = 16'h0000;
  localparam logic [31:0] LAYER_SIZE_RST = 32'h0000_0000;
  localparam int CLK_HZ = 20_000_000;
  localparam int SYS_CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int POS_UNIT_NS = 10;
  localparam int POS_STEP = SYS_CLK_NS / POS_UNIT_NS;
  localparam int HP_UNIT_NS = 30;
  localparam int HP_SCALE = HP_UNIT_NS / POS_UNIT_NS;
  localparam int HCLAMP_UNIT_NS = 480;
  localparam int HCLAMP_SCALE = HCLAMP_UNIT_NS / POS_UNIT_NS;
  localparam int DTO_REF_MHZ = 300;
  localparam int DTO_MODULUS = 8192;
  localparam int DTO_GAIN = DTO_REF_MHZ * 1_000_000 / CLK_HZ;
  localparam int HSYNC_WIDTH_NS = 4700;
  localparam int HSYNC_WIDTH_POS = HSYNC_WIDTH_NS / POS_UNIT_NS;
  localparam int VSYNC_LINES = 3;
  localparam int REFRESH_NS = 15600;
  localparam int BUS_SLOW_MHZ = 66;
  localparam int BUS_FAST_MHZ = 100;
  localparam int REFRESH_CYC_SLOW = REFRESH_NS * BUS_SLOW_MHZ / 1000;
  localparam int REFRESH_CYC_FAST = REFRESH_NS * BUS_FAST_MHZ / 1000;
  localparam int CLK_SWITCH_CYC = 2;
  typedef struct packed {
    logic h;
    logic v;
  } sync_pair_t;
  typedef struct packed {
    logic [3:0] r;
    logic [3:0] g;
    logic [3:0] b;
  } colour_t;
endpackage : display_timing_pkg

// ==== hdl/display_clock_sync_timing.sv ====
// display clock, sync and screen region timing with apb register slave
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module display_clock_sync_timing
  import display_timing_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [display_timing_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic end_of_init_instruction,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire display_timing_pkg::sync_pair_t sync_in,
  output display_timing_pkg::sync_pair_t sync_out,
  output display_timing_pkg::sync_pair_t sync_oe_n,
  input wire display_timing_pkg::colour_t layer_colour,
  input wire logic [3:0] layer_alpha,
  input wire logic layer_cor,
  output display_timing_pkg::colour_t pixel_colour,
  output logic [3:0] pixel_alpha,
  output logic blank_out,
  output logic contrast_reduction_out,
  output logic layer_fetch,
  output logic pixel_clock,
  output logic bus_clock_fast,
  output logic bus_clock_enable,
  output logic [15:0] refresh_interval,
  output logic pll_bypass,
  output logic pll_off,
  output logic h_irq,
  output logic v_irq
);
  import display_timing_pkg::*;

  function automatic logic in_window(input logic [15:0] val,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    in_window = (val >= lo) && (val < hi);
  endfunction : in_window

  // register file
  logic [15:0] sys_config_two, next_sys_config_two;
  logic [10:0] pixel_factor_field, next_pixel_factor_field;
  logic [15:0] sync_control, next_sync_control;
  logic [9:0] lines_per_field, next_lines_per_field;
  logic [11:0] horizontal_period, next_horizontal_period;
  logic [9:0] vertical_sync_delay, next_vertical_sync_delay;
  logic [10:0] horizontal_sync_delay, next_horizontal_sync_delay;
  logic [9:0] vertical_clamp_begin, next_vertical_clamp_begin;
  logic [9:0] vertical_clamp_end, next_vertical_clamp_end;
  logic [8:0] horizontal_clamp_begin, next_horizontal_clamp_begin;
  logic [8:0] horizontal_clamp_end, next_horizontal_clamp_end;
  logic [15:0] background_colour, next_background_colour;
  logic [31:0] layer_size, next_layer_size;
  logic init_done, next_init_done;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [10:0] line, next_line;
  logic master_slave_select;

  assign master_slave_select = sync_control[MASTER_SLAVE_SELECT_BIT];

  always_comb
  begin
    logic wr;
    logic [31:0] rd;
    logic hit;
    wr = psel && penable && pready && pwrite;
    rd = 32'h0000_0000;
    hit = 1'b1;
    next_sys_config_two = sys_config_two;
    next_pixel_factor_field = pixel_factor_field;
    next_sync_control = sync_control;
    next_lines_per_field = lines_per_field;
    next_horizontal_period = horizontal_period;
    next_vertical_sync_delay = vertical_sync_delay;
    next_horizontal_sync_delay = horizontal_sync_delay;
    next_vertical_clamp_begin = vertical_clamp_begin;
    next_vertical_clamp_end = vertical_clamp_end;
    next_horizontal_clamp_begin = horizontal_clamp_begin;
    next_horizontal_clamp_end = horizontal_clamp_end;
    next_background_colour = background_colour;
    next_layer_size = layer_size;
    next_init_done = init_done | end_of_init_instruction;
    unique case (paddr)
      SYS_CONFIG_TWO_OFS: rd = {16'h0000, sys_config_two};
      PIXEL_FREQ_FACTOR_OFS: rd = {21'h000000, pixel_factor_field};
      SYNC_CONTROL_OFS: rd = {16'h0000, sync_control};
      LINES_PER_FIELD_OFS: rd = {22'h000000, lines_per_field};
      HORIZONTAL_PERIOD_OFS: rd = {20'h00000, horizontal_period};
      VERTICAL_SYNC_DELAY_OFS: rd = {22'h000000, vertical_sync_delay};
      HORIZONTAL_SYNC_DELAY_OFS: rd = {21'h000000, horizontal_sync_delay};
      VERTICAL_CLAMP_BEGIN_OFS: rd = {22'h000000, vertical_clamp_begin};
      VERTICAL_CLAMP_END_OFS: rd = {22'h000000, vertical_clamp_end};
      HORIZONTAL_CLAMP_BEGIN_OFS: rd = {23'h000000, horizontal_clamp_begin};
      HORIZONTAL_CLAMP_END_OFS: rd = {23'h000000, horizontal_clamp_end};
      BACKGROUND_COLOUR_OFS: rd = {16'h0000, background_colour};
      LAYER_SIZE_OFS: rd = layer_size;
      TIMING_STATUS_OFS: rd = {5'h00, line, 13'h0000,
                               bus_clock_fast, init_done, master_slave_select};
      default: hit = 1'b0;
    endcase
    if (wr)
    begin
      unique case (paddr)
        SYS_CONFIG_TWO_OFS:
          if (!init_done)
            next_sys_config_two = {7'h00, pwdata[BUS_SEL_BIT], 8'h00};
        PIXEL_FREQ_FACTOR_OFS: next_pixel_factor_field = pwdata[10:0];
        SYNC_CONTROL_OFS: next_sync_control = pwdata[15:0];
        LINES_PER_FIELD_OFS: next_lines_per_field = pwdata[9:0];
        HORIZONTAL_PERIOD_OFS: next_horizontal_period = pwdata[11:0];
        VERTICAL_SYNC_DELAY_OFS: next_vertical_sync_delay = pwdata[9:0];
        HORIZONTAL_SYNC_DELAY_OFS:
          next_horizontal_sync_delay = pwdata[10:0];
        VERTICAL_CLAMP_BEGIN_OFS: next_vertical_clamp_begin = pwdata[9:0];
        VERTICAL_CLAMP_END_OFS: next_vertical_clamp_end = pwdata[9:0];
        HORIZONTAL_CLAMP_BEGIN_OFS:
          next_horizontal_clamp_begin = pwdata[8:0];
        HORIZONTAL_CLAMP_END_OFS: next_horizontal_clamp_end = pwdata[8:0];
        BACKGROUND_COLOUR_OFS: next_background_colour = pwdata[15:0];
        LAYER_SIZE_OFS: next_layer_size = pwdata;
        default: next_init_done = init_done | end_of_init_instruction;
      endcase
    end
    // one wait state keeps pready and prdata straight from flops
    next_pready = psel && penable && !pready;
    next_prdata = next_pready ? rd : 32'h0000_0000;
    next_pslverr = next_pready && !hit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sys_config_two <= SYS_CONFIG_TWO_RST;
      pixel_factor_field <= PIXEL_FACTOR_RST;
      sync_control <= SYNC_CONTROL_RST;
      lines_per_field <= LINES_PER_FIELD_RST;
      horizontal_period <= HORIZONTAL_PERIOD_RST;
      vertical_sync_delay <= VERTICAL_SYNC_DELAY_RST;
      horizontal_sync_delay <= HORIZONTAL_SYNC_DELAY_RST;
      vertical_clamp_begin <= VERTICAL_CLAMP_BEGIN_RST;
      vertical_clamp_end <= VERTICAL_CLAMP_END_RST;
      horizontal_clamp_begin <= HORIZONTAL_CLAMP_BEGIN_RST;
      horizontal_clamp_end <= HORIZONTAL_CLAMP_END_RST;
      background_colour <= BACKGROUND_COLOUR_RST;
      layer_size <= LAYER_SIZE_RST;
      init_done <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      sys_config_two <= next_sys_config_two;
      pixel_factor_field <= next_pixel_factor_field;
      sync_control <= next_sync_control;
      lines_per_field <= next_lines_per_field;
      horizontal_period <= next_horizontal_period;
      vertical_sync_delay <= next_vertical_sync_delay;
      horizontal_sync_delay <= next_horizontal_sync_delay;
      vertical_clamp_begin <= next_vertical_clamp_begin;
      vertical_clamp_end <= next_vertical_clamp_end;
      horizontal_clamp_begin <= next_horizontal_clamp_begin;
      horizontal_clamp_end <= next_horizontal_clamp_end;
      background_colour <= next_background_colour;
      layer_size <= next_layer_size;
      init_done <= next_init_done;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // bus clock switch: gate, swap, ungate so no runt pulse reaches the bus
  typedef enum logic [1:0] {CS_RUN, CS_GATE, CS_SWAP} clk_switch_t;
  clk_switch_t cs_state, next_cs_state;
  logic [1:0] cs_cnt, next_cs_cnt;
  logic next_bus_clock_fast, next_bus_clock_enable;
  logic [15:0] next_refresh_interval;

  always_comb
  begin
    next_cs_state = cs_state;
    next_cs_cnt = cs_cnt + 2'd1;
    next_bus_clock_fast = bus_clock_fast;
    next_bus_clock_enable = bus_clock_enable;
    unique case (cs_state)
      CS_RUN:
      begin
        next_cs_cnt = 2'd0;
        if (sys_config_two[BUS_SEL_BIT] != bus_clock_fast)
        begin
          next_bus_clock_enable = 1'b0;
          next_cs_state = CS_GATE;
        end
      end
      CS_GATE:
        if (cs_cnt == 2'(CLK_SWITCH_CYC - 1))
        begin
          next_bus_clock_fast = sys_config_two[BUS_SEL_BIT];
          next_cs_cnt = 2'd0;
          next_cs_state = CS_SWAP;
        end
      CS_SWAP:
        if (cs_cnt == 2'(CLK_SWITCH_CYC - 1))
        begin
          next_bus_clock_enable = 1'b1;
          next_cs_state = CS_RUN;
        end
    endcase
    next_refresh_interval = next_bus_clock_fast ? 16'(REFRESH_CYC_FAST)
                                                : 16'(REFRESH_CYC_SLOW);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cs_state <= CS_RUN;
      cs_cnt <= 2'd0;
      bus_clock_fast <= 1'b0;
      bus_clock_enable <= 1'b1;
      refresh_interval <= 16'(REFRESH_CYC_SLOW);
      pll_bypass <= 1'b0;
      pll_off <= 1'b0;
    end
    else
    begin
      cs_state <= next_cs_state;
      cs_cnt <= next_cs_cnt;
      bus_clock_fast <= next_bus_clock_fast;
      bus_clock_enable <= next_bus_clock_enable;
      refresh_interval <= next_refresh_interval;
      pll_bypass <= idle_mode | sleep_mode;
      pll_off <= sleep_mode;
    end
  end

  // sync timing; pins pass two flops before any logic reads them
  sync_pair_t pin_meta, pin_sync;
  logic h_prev, v_prev, v_pending, next_v_pending;
  logic [14:0] pos, next_pos;
  logic [11:0] hpix, next_hpix;
  logic [12:0] dto_acc, next_dto_acc;
  logic next_pixel_clock, h_start, h_eff, v_eff, hs_gen, vs_gen;
  logic [15:0] dto_sum;
  logic [10:0] lines_total;
  sync_pair_t next_sync_out;

  always_comb
  begin
    logic h_rise_pin, v_rise_pin, h_wrap;
    hs_gen = pos < 15'(HSYNC_WIDTH_POS);
    vs_gen = line <= 11'(VSYNC_LINES);
    h_eff = master_slave_select ? hs_gen : pin_sync.h ^ sync_control[HP_BIT];
    v_eff = master_slave_select ? vs_gen : pin_sync.v ^ sync_control[VP_BIT];
    h_rise_pin = h_eff && !h_prev;
    v_rise_pin = v_eff && !v_prev;
    lines_total = (lines_per_field == 10'h000) ? 11'h400
                                               : {1'b0, lines_per_field};
    h_wrap = pos + 15'(POS_STEP) >= 15'(horizontal_period * HP_SCALE);
    h_start = master_slave_select ? h_wrap : h_rise_pin;
    next_pos = h_start ? 15'h0000
                       : ((pos == 15'h7FFF) ? pos : pos + 15'(POS_STEP));
    next_v_pending = (v_pending && !h_start) || (!master_slave_select && v_rise_pin);
    next_line = line;
    if (h_start)
    begin
      if (v_pending || (master_slave_select && line >= lines_total))
        next_line = 11'h001;
      else if (line != 11'h7FF)
        next_line = line + 11'h001;
    end
    // step never reaches the modulus up to factor 546, so one tick
    // per cycle at most; larger factors, which software avoids, saturate
    dto_sum = {3'h0, dto_acc} + 16'(pixel_factor_field * DTO_GAIN);
    next_pixel_clock = dto_sum >= 16'(DTO_MODULUS);
    next_dto_acc = next_pixel_clock ? 13'(dto_sum - 16'(DTO_MODULUS))
                                    : dto_sum[12:0];
    if (h_start)
      next_dto_acc = 13'h0000;
    next_hpix = h_start ? 12'h000
                : ((pixel_clock && hpix != 12'hFFF) ? hpix + 12'h001 : hpix);
    next_sync_out.h = master_slave_select && (hs_gen ^ sync_control[HP_BIT]);
    next_sync_out.v = master_slave_select && (vs_gen ^ sync_control[VP_BIT]);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      h_prev <= 1'b0;
      v_prev <= 1'b0;
      v_pending <= 1'b0;
      pos <= 15'h0000;
      line <= 11'h001;
      hpix <= 12'h000;
      dto_acc <= 13'h0000;
      pixel_clock <= 1'b0;
      sync_out <= '0;
      sync_oe_n <= '1;
      h_irq <= 1'b0;
      v_irq <= 1'b0;
    end
    else
    begin
      pin_meta <= sync_in;
      pin_sync <= pin_meta;
      h_prev <= h_eff;
      v_prev <= v_eff;
      v_pending <= next_v_pending;
      pos <= next_pos;
      line <= next_line;
      hpix <= next_hpix;
      dto_acc <= next_dto_acc;
      pixel_clock <= next_pixel_clock;
      // entering master restarts the counters to keep the phase jump small
      if (!master_slave_select && sync_control[MASTER_SLAVE_SELECT_BIT] != next_sync_control[MASTER_SLAVE_SELECT_BIT])
      begin
        pos <= 15'h0000;
        line <= 11'h001;
      end
      sync_out <= next_sync_out;
      sync_oe_n <= {!master_slave_select, !master_slave_select};
      h_irq <= h_eff && !h_prev;
      v_irq <= v_eff && !v_prev;
    end
  end

  // screen regions: clamp, pixel layer, background
  logic next_blank, next_cor, next_layer_fetch;
  colour_t next_pixel_colour;
  logic [3:0] next_pixel_alpha;

  always_comb
  begin
    logic clamp, layer;
    logic [15:0] h_end, v_end;
    clamp = in_window({5'h00, line}, {6'h00, vertical_clamp_begin},
                      {6'h00, vertical_clamp_end} + 16'h0001)
            || in_window({1'b0, pos},
                         16'(horizontal_clamp_begin * HCLAMP_SCALE),
                         16'(horizontal_clamp_end * HCLAMP_SCALE));
    h_end = {5'h00, horizontal_sync_delay} + {5'h00, layer_size[10:0]};
    v_end = {6'h00, vertical_sync_delay}
            + {6'h00, layer_size[LAYER_H_LSB +: 10]};
    layer = in_window({4'h0, hpix}, {5'h00, horizontal_sync_delay}, h_end)
            && in_window({5'h00, line}, {6'h00, vertical_sync_delay},
                         v_end);
    next_layer_fetch = layer && !clamp;
    next_blank = 1'b0;
    next_cor = 1'b0;
    next_pixel_colour = background_colour[15:4];
    next_pixel_alpha = background_colour[3:0];
    if (clamp)
    begin
      next_pixel_colour = '0;
      next_pixel_alpha = 4'h0;
      next_blank = 1'b1;
    end
    else if (layer)
    begin
      next_pixel_colour = layer_colour;
      next_pixel_alpha = layer_alpha;
      next_cor = layer_cor;
    end
    // blank polarity bit set means active high; contrast bit set inverts
    next_blank = next_blank ^ !sync_control[BLANKP_BIT];
    next_cor = next_cor ^ sync_control[CORP_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pixel_colour <= '0;
      pixel_alpha <= 4'h0;
      blank_out <= 1'b0;
      contrast_reduction_out <= 1'b0;
      layer_fetch <= 1'b0;
    end
    else
    begin
      pixel_colour <= next_pixel_colour;
      pixel_alpha <= next_pixel_alpha;
      blank_out <= next_blank;
      contrast_reduction_out <= next_cor;
      layer_fetch <= next_layer_fetch;
    end
  end
endmodule : display_clock_sync_timing

// ==== verif/display_timing_asserts.sv ====
// port assertions for the display clock and sync timing block
`timescale 1ns/100ps
module display_timing_asserts
  import display_timing_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pready,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire display_timing_pkg::sync_pair_t sync_in,
  input wire display_timing_pkg::sync_pair_t sync_out,
  input wire display_timing_pkg::sync_pair_t sync_oe_n,
  input wire logic bus_clock_fast,
  input wire logic bus_clock_enable,
  input wire logic [15:0] refresh_interval,
  input wire logic pll_bypass,
  input wire logic pll_off,
  input wire logic h_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
  property p_refresh; bus_clock_enable |-> refresh_interval ==
    (bus_clock_fast ? 16'h0618 : 16'h0405); endproperty
  a_refresh: assert property (p_refresh) else $error("refresh count");
  property p_gap; $changed(bus_clock_fast) |-> !bus_clock_enable; endproperty
  a_gap: assert property (p_gap) else $error("clock switch glitch");
  property p_gap_end; $fell(bus_clock_enable) |-> ##[1:8] bus_clock_enable;
  endproperty
  a_gap_end: assert property (p_gap_end) else $error("switch stuck");
  property p_pll; pll_off == $past(sleep_mode) &&
    pll_bypass == ($past(idle_mode) || $past(sleep_mode)); endproperty
  a_pll: assert property (p_pll) else $error("pll control");
  property p_irq_once; h_irq |=> !h_irq; endproperty
  a_irq_once: assert property (p_irq_once) else $error("long h irq");
  property p_irq_edge; $rose(sync_in.h) && sync_oe_n.h |-> ##[2:4] h_irq;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("missed h irq");
  property p_slave_pins; sync_oe_n.h |-> sync_oe_n.v && !sync_out.h;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("pin dir");
  c_slave_irq: cover property (h_irq && sync_oe_n.h);
  c_fast: cover property ($rose(bus_clock_fast));
  c_master: cover property ($fell(sync_oe_n.h));
endmodule : display_timing_asserts
bind display_clock_sync_timing display_timing_asserts
  display_timing_asserts_inst (.sys_clk, .srst, .pready, .idle_mode,
  .sleep_mode, .sync_in, .sync_out, .sync_oe_n, .bus_clock_fast,
  .bus_clock_enable, .refresh_interval, .pll_bypass, .pll_off, .h_irq);

// ==== verif/sync_source_model.sv ====
// far-side sync source: separate h and v pulses for slave mode
`timescale 1ns/100ps
module sync_source_model
  import display_timing_pkg::*;
(
  input wire logic sys_clk,
  input wire logic run,
  output display_timing_pkg::sync_pair_t sync_src
);
  int pos = 0;
  int line = 0;
  // both pins rest low while stopped, the idle level of normal polarity
  always @(posedge sys_clk)
  begin
    pos <= !run ? pos : (pos == 199) ? 0 : pos + 1;
    line <= (!run || pos != 199) ? line : (line == 5) ? 0 : line + 1;
    sync_src.h <= run && pos < 20;
    sync_src.v <= run && line == 0;
  end
endmodule : sync_source_model

// ==== verif/tb_top.sv ====
// self-checking bench for the display clock and sync timing block
`timescale 1ns/100ps
module tb_top;
  import display_timing_pkg::*;
  logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic end_of_init_instruction = 0, idle_mode = 0, sleep_mode = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, blank_out, contrast_reduction_out, saw = 0;
  logic layer_fetch, pixel_clock, bus_clock_fast, bus_clock_enable, h_irq;
  logic pll_bypass, pll_off, v_irq, layer_cor = 0;
  logic [15:0] refresh_interval;
  logic [3:0] pixel_alpha, layer_alpha = '0;
  colour_t pixel_colour, layer_colour = '0;
  sync_pair_t sync_in, sync_out, sync_oe_n, src;
  int n_errors = 0, tests_run = 0, per = 0, npix = 0, nh = 0, nv = 0;
  // pins are driven by the source model unless the block drives them
  assign sync_in = {sync_oe_n.h ? src.h : sync_out.h,
                    sync_oe_n.v ? src.v : sync_out.v};
  initial forever #25 sys_clk = ~sys_clk;
  display_clock_sync_timing display_clock_sync_timing_inst (.sys_clk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .end_of_init_instruction, .idle_mode, .sleep_mode, .sync_in, .sync_out,
    .sync_oe_n, .layer_colour, .layer_alpha, .layer_cor, .pixel_colour,
    .pixel_alpha, .blank_out, .contrast_reduction_out, .layer_fetch,
    .pixel_clock, .bus_clock_fast, .bus_clock_enable, .refresh_interval,
    .pll_bypass, .pll_off, .h_irq, .v_irq);
  sync_source_model sync_source_model_inst (.sys_clk, .run, .sync_src(src));
  task tally_and_finish(input int stuck);
    n_errors += stuck;
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    if (seen !== exp) n_errors++;
  endtask : check
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge sys_clk);
    if (k == 20) tally_and_finish(1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("register", rd, exp);
  endtask : rd_chk
  task tick;
    @(posedge sys_clk);
    per++;
    npix += pixel_clock;
    saw |= layer_fetch;
    nh += h_irq;
    nv += v_irq;
  endtask : tick
  // the line is timed between two rises, never from the mode switch itself
  task wait_rise;
    int k;
    for (k = 0; k < 3000 && sync_out.h !== 1'b0; k++) tick();
    for (k = k; k < 3000 && sync_out.h !== 1'b1; k++) tick();
    if (k >= 3000) tally_and_finish(1);
  endtask : wait_rise
  initial
  begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rd_chk(PIXEL_FREQ_FACTOR_OFS, 32'h148);
    rd_chk(LINES_PER_FIELD_OFS, 32'h271);
    rd_chk(VERTICAL_SYNC_DELAY_OFS, 32'h20);
    rd_chk(HORIZONTAL_SYNC_DELAY_OFS, 32'h48);
    rd_chk(VERTICAL_CLAMP_END_OFS, 32'h5);
    rd_chk(SYS_CONFIG_TWO_OFS, 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, PIXEL_FREQ_FACTOR_OFS, 32'hF556);
    rd_chk(PIXEL_FREQ_FACTOR_OFS, 32'h556);
    apb(1'b1, PIXEL_FREQ_FACTOR_OFS, 32'h148);
    apb(1'b1, SYS_CONFIG_TWO_OFS, 32'h100);
    repeat (10) tick();
    check("bus clock", {bus_clock_fast, bus_clock_enable,
      refresh_interval}, 32'h30618);
    end_of_init_instruction <= 1'b1;
    apb(1'b1, SYS_CONFIG_TWO_OFS, 32'h0);
    rd_chk(SYS_CONFIG_TWO_OFS, 32'h100);
    nh = 0;
    nv = 0;
    run <= 1'b1;
    repeat (1000) tick();
    check("h irqs", nh, 5);
    check("v irqs", nv, 1);
    run <= 1'b0;
    apb(1'b1, HORIZONTAL_PERIOD_OFS, 32'h1F4);
    apb(1'b1, SYNC_CONTROL_OFS, 32'h41);
    repeat (3) tick();
    check("clamp", {pixel_colour, blank_out,
      contrast_reduction_out, sync_oe_n}, 32'h8);
    wait_rise();
    per = 0;
    npix = 0;
    saw = 0;
    wait_rise();
    check("line period", per, 300);
    check("pixels", 32'(npix > 178 && npix < 182), 32'h1);
    check("fetch", saw, 32'h0);
    apb(1'b1, LAYER_SIZE_OFS, 32'h0008_0010);
    apb(1'b1, VERTICAL_SYNC_DELAY_OFS, 32'h4);
    apb(1'b1, BACKGROUND_COLOUR_OFS, 32'hABC7);
    saw = 0;
    repeat (3000) tick();
    check("fetch on", saw, 32'h1);
    // late in a line below the layer: only the background can show
    wait_rise();
    repeat (200) tick();
    check("background", {pixel_colour, pixel_alpha, blank_out},
      32'h1578E);
    sleep_mode <= 1'b1;
    repeat (2) tick();
    check("sleep", {pll_off, pll_bypass}, 32'h3);
    tally_and_finish(0);
  end
endmodule : tb_top
